// >>> rtl/tmon_defs.vh
// constants for the thermal monitor serial slave
`ifndef TMON_DEFS_VH
`define TMON_DEFS_VH

`define DEV_ADDR        7'h4C
`define DEV_ADDR_ALT    7'h4D
`define ARA_ADDR        7'h0C
`define PTR_ONESHOT     8'h0F
`define PTR_FILT_RD     8'h22
`define PTR_FILT_WR     8'h22
`define PTR_STATUS      8'h02
`define FILT_RESET      8'h01
`define FILT_TO_BIT     7
`define TIMEOUT_MS      25
`define CLK_HZ          40000000
`define TIMEOUT_CYC     ((`CLK_HZ / 1000) * `TIMEOUT_MS)

`endif

// >>> rtl/line_sync.v
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg meta_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // line_sync
`default_nettype wire

// >>> rtl/idle_timer.v
// bus inactivity timer
`timescale 1ns/1ps
`default_nettype none
module idle_timer #(
  parameter LIMIT = 1000000
) (
  input  wire clk,
  input  wire rst_n,
  input  wire enable,
  input  wire activity,
  output reg  expired
);
  reg [31:0] cnt_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= 32'h00000000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!enable || activity) begin
        cnt_r <= 32'h00000000;
      end else if (cnt_r == LIMIT - 1) begin
        cnt_r   <= 32'h00000000;
        expired <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h00000001;
      end
    end
  end
endmodule // idle_timer
`default_nettype wire

// >>> rtl/tmon_serial_slave.v
// serial bus slave front end of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "tmon_defs.vh"

module tmon_serial_slave #(
  parameter ALT_ADDR    = 0,
  parameter TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       serial_clock_in,
  input  wire       serial_data_in,
  output reg        serial_data_out,
  output reg        serial_data_oe,
  input  wire       alert_mode,
  input  wire       fault_active,
  input  wire       status_latched,
  input  wire [7:0] reg_rd_data,
  output reg  [7:0] reg_ptr,
  output reg  [7:0] reg_wr_data,
  output reg        reg_wr_stb,
  output reg        status_rd_stb,
  output reg        oneshot_stb,
  output reg        alert_out,
  output reg        alert_oe,
  output reg  [7:0] fault_filter
);
  // ****************************************
  // reset and line sampling
  // ****************************************
  localparam [6:0] OWN_ADDR = ALT_ADDR ? `DEV_ADDR_ALT : `DEV_ADDR;

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ACK  = 3'h2;
  localparam [2:0] S_WRB  = 3'h3;
  localparam [2:0] S_RDB  = 3'h4;
  localparam [2:0] S_RACK = 3'h5;
  localparam [2:0] S_SKIP = 3'h6;

  reg  rst_a_r;
  reg  rst_n_r;
  wire scl_s;
  wire sda_s;
  reg  scl_d_r;
  reg  sda_d_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  line_sync u_scl_sync (
    .clk   (clk),
    .rst_n (rst_n_r),
    .din   (serial_clock_in),
    .dout  (scl_s)
  );

  line_sync u_sda_sync (
    .clk   (clk),
    .rst_n (rst_n_r),
    .din   (serial_data_in),
    .dout  (sda_s)
  );

  // idle level after reset, so the release makes no false edge
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // both lines judged on synced copies, so pin skew stays out
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************
  // bus inactivity timeout
  // ****************************************
  wire timeout;
  wire bus_act = (scl_s ^ scl_d_r) | (sda_s ^ sda_d_r);
  reg  [2:0] state_r;

  // limitation: a bus left idle between frames never times out
  // idle timer runs inside a transfer
  idle_timer #(
    .LIMIT (TIMEOUT_CYC)
  ) u_idle (
    .clk      (clk),
    .rst_n    (rst_n_r),
    .enable   (fault_filter[`FILT_TO_BIT] && state_r != S_IDLE),
    .activity (bus_act),
    .expired  (timeout)
  );

  // ****************************************
  // byte engine
  // ****************************************
  reg  [3:0] bit_r;
  reg  [7:0] shift_r;
  reg        rd_r;
  reg        ara_r;
  reg  [1:0] wcnt_r;
  reg        ara_done_r;
  reg        alert_hold_r;
  wire [7:0] own_resp = {OWN_ADDR, 1'b1};
  // filter read location is served here, not by the core
  wire [7:0] rd_byte  = (reg_ptr == `PTR_FILT_RD) ? fault_filter
                                                  : reg_rd_data;

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r         <= S_IDLE;
      bit_r           <= 4'h0;
      shift_r         <= 8'h00;
      rd_r            <= 1'b0;
      ara_r           <= 1'b0;
      wcnt_r          <= 2'h0;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
      // pointer has no defined power-on value; zero serves
      reg_ptr         <= 8'h00;
      reg_wr_data     <= 8'h00;
      reg_wr_stb      <= 1'b0;
      status_rd_stb   <= 1'b0;
      oneshot_stb     <= 1'b0;
      fault_filter    <= `FILT_RESET;
      ara_done_r      <= 1'b0;
    end else begin
      reg_wr_stb    <= 1'b0;
      status_rd_stb <= 1'b0;
      oneshot_stb   <= 1'b0;
      ara_done_r    <= 1'b0;
      if (start_c) begin
        state_r        <= S_ADDR;
        bit_r          <= 4'h0;
        wcnt_r         <= 2'h0;
        serial_data_oe <= 1'b0;
      end else if (stop_c || timeout) begin
        state_r        <= S_IDLE;
        serial_data_oe <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            serial_data_oe <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (shift_r[7:1] == OWN_ADDR) begin
                rd_r           <= shift_r[0];
                ara_r          <= 1'b0;
                state_r        <= S_ACK;
                serial_data_out<= 1'b0;
                serial_data_oe <= 1'b1;
              end else if (shift_r[7:1] == `ARA_ADDR && shift_r[0]
                           && alert_hold_r) begin
                rd_r           <= 1'b1;
                ara_r          <= 1'b1;
                state_r        <= S_ACK;
                serial_data_out<= 1'b0;
                serial_data_oe <= 1'b1;
              end else begin
                state_r <= S_SKIP;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (rd_r) begin
                shift_r         <= ara_r ? own_resp : rd_byte;
                serial_data_out <= ara_r ? own_resp[7] : rd_byte[7];
                serial_data_oe  <= ara_r ? ~own_resp[7] : ~rd_byte[7];
                // strobe lets the core clear its latched flags
                if (!ara_r && reg_ptr == `PTR_STATUS)
                  status_rd_stb <= 1'b1;
                state_r <= S_RDB;
              end else begin
                serial_data_oe <= 1'b0;
                state_r        <= S_WRB;
              end
              bit_r <= 4'h0;
            end
          end
          S_WRB: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (wcnt_r == 2'h0) begin
                reg_ptr        <= shift_r;
                wcnt_r         <= 2'h1;
                serial_data_out<= 1'b0;
                serial_data_oe <= 1'b1;
                state_r        <= S_ACK;
              end else if (wcnt_r == 2'h1) begin
                wcnt_r <= 2'h2;
                if (reg_ptr == `PTR_ONESHOT) begin
                  // one pulse; the core drops back to standby
                  oneshot_stb <= 1'b1;
                end else if (reg_ptr == `PTR_FILT_WR) begin
                  fault_filter <= shift_r;
                end else begin
                  reg_wr_data <= shift_r;
                  reg_wr_stb  <= 1'b1;
                end
                serial_data_out<= 1'b0;
                serial_data_oe <= 1'b1;
                state_r        <= S_ACK;
              end else begin
                // third byte gets no acknowledge
                state_r <= S_SKIP;
              end
            end
          end
          S_RDB: begin
            // data moves only on falling clock
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
              if (serial_data_oe == 1'b0 && shift_r[7] && !sda_s)
                state_r <= S_SKIP;
            end else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                serial_data_oe <= 1'b0;
                state_r        <= S_RACK;
              end else begin
                shift_r         <= {shift_r[6:0], 1'b0};
                serial_data_out <= shift_r[6];
                serial_data_oe  <= ~shift_r[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              if (ara_r)
                ara_done_r <= 1'b1;
              state_r <= S_SKIP;
            end
          end
          S_SKIP: begin
            // off the line until the next start or stop
            serial_data_oe <= 1'b0;
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // alert pin
  // ****************************************
  // drives low only; pin idles released by the pull-up
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      alert_hold_r <= 1'b0;
      alert_out    <= 1'b0;
      alert_oe     <= 1'b0;
    end else begin
      // a fresh fault wins over a release in the same cycle
      // raised by fault_active while alert_mode is set
      if (alert_mode && fault_active)
        alert_hold_r <= 1'b1;
      else if (ara_done_r && !status_latched)
        alert_hold_r <= 1'b0;
      else if (!alert_mode)
        alert_hold_r <= 1'b0;
      alert_out <= 1'b0;
      alert_oe  <= alert_hold_r;
    end
  end
endmodule // tmon_serial_slave
`default_nettype wire

// >>> tb/tmon_monitor.sv
// port checker for the serial slave, bound to the slave module
`timescale 1ns/1ps
`default_nettype none
module tmon_monitor #(
  parameter TIMEOUT_CYC = 200
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       serial_clock_in,
  input wire logic       serial_data_out,
  input wire logic       serial_data_oe,
  input wire logic       alert_mode,
  input wire logic       fault_active,
  input wire logic       status_latched,
  input wire logic [7:0] reg_ptr,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_wr_stb,
  input wire logic       status_rd_stb,
  input wire logic       oneshot_stb,
  input wire logic       alert_out,
  input wire logic       alert_oe,
  input wire logic [7:0] fault_filter
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  oe_low_only_a: assert property (serial_data_oe |-> !serial_data_out)
    else $error("data line driven high");
  oneshot_ptr_a: assert property (oneshot_stb |-> reg_ptr == 8'h0F)
    else $error("one-shot pulse off its location");
  oneshot_nostore_a: assert property (reg_wr_stb |-> reg_ptr != 8'h0F)
    else $error("one-shot data stored");
  filter_reset_a: assert property ($rose(rstn) |-> fault_filter == 8'h01)
    else $error("filter reset value wrong");
  filter_store_a: assert property (reg_wr_stb |-> reg_ptr != 8'h22)
    else $error("filter write passed to core");
  filter_hold_a: assert property ($changed(fault_filter) |->
    reg_ptr == 8'h22) else $error("filter changed alone");
  wr_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("store strobe too long");
  data_steady_a: assert property ((serial_clock_in &&
    $past(serial_clock_in, 3)) |-> $stable(serial_data_oe))
    else $error("data moved with clock high");
  alert_raise_a: assert property ((alert_mode && fault_active)[*4]
    |-> alert_oe && !alert_out) else $error("alert not raised");
  alert_keep_a: assert property ($fell(alert_oe) |-> !$past(alert_mode)
    || (!$past(fault_active) && !$past(status_latched)))
    else $error("alert released too early");
  status_ptr_a: assert property (status_rd_stb |-> reg_ptr == 8'h02)
    else $error("status strobe off its location");
  cover property (oneshot_stb);
  cover property ($fell(alert_oe));
  cover property ($changed(fault_filter));
endmodule // tmon_monitor

bind tmon_serial_slave tmon_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon_u (
  .clk(clk), .rstn(rstn), .serial_clock_in(serial_clock_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .alert_mode(alert_mode), .fault_active(fault_active),
  .status_latched(status_latched), .reg_ptr(reg_ptr),
  .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
  .status_rd_stb(status_rd_stb), .oneshot_stb(oneshot_stb),
  .alert_out(alert_out), .alert_oe(alert_oe), .fault_filter(fault_filter)
);
`default_nettype wire

// >>> tb/bus_master.sv
// bus master model for the two-wire serial link
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // ****************************************
  // bit and byte tasks
  // ****************************************
  // clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  // data moves only in the low half
  task automatic bit_x(input logic b, output logic s);
    w(2);
    sda_low = !b;
    w(2);
    scl = 1'b1;
    w(2);
    s = sda;
    w(2);
    scl = 1'b0;
  endtask
  // low before the clock rises, rise while high
  task automatic stop();
    w(2);
    sda_low = 1'b1;
    w(2);
    scl = 1'b1;
    w(2);
    sda_low = 1'b0;
    w(4);
  endtask
  // eight bits msb first, then the ack clock
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // one byte read, closed by no-acknowledge
  // zero bits of o pull the line low as a rival responder would
  task automatic rbyte(input logic [7:0] o, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(o[i], s);
      v[i] = s;
    end
    bit_x(1'b1, s);
  endtask
endmodule // bus_master
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       alert_mode = 1'b0;
  logic       fault_active = 1'b0;
  logic       status_latched = 1'b0;
  logic       scl, sda_low, a1;
  logic [7:0] wr_last, p, d, v;
  logic [3:0] ak;
  int         seed = 64, checked = 0, error_cnt = 0, s0;
  int         wr_cnt = 0, os_cnt = 0, st_cnt = 0;
  wire        sda, serial_data_out, serial_data_oe, reg_wr_stb;
  wire        status_rd_stb, oneshot_stb, alert_out, alert_oe;
  wire  [7:0] reg_ptr, reg_wr_data, fault_filter, reg_rd_data;
  // ****************************************
  // wiring and models
  // ****************************************
  // released line is pulled up
  assign sda = !sda_low && !(serial_data_oe && !serial_data_out);
  function automatic logic [7:0] rdv(input logic [7:0] x);
    return {x[3:0], x[7:4]} ^ 8'h5A;
  endfunction
  assign reg_rd_data = rdv(reg_ptr);
  bus_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  tmon_serial_slave #(.TIMEOUT_CYC(200)) dut_u (
    .clk(clk), .rstn(rstn), .serial_clock_in(scl), .serial_data_in(sda),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .alert_mode(alert_mode), .fault_active(fault_active),
    .status_latched(status_latched), .reg_rd_data(reg_rd_data),
    .reg_ptr(reg_ptr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
    .status_rd_stb(status_rd_stb), .oneshot_stb(oneshot_stb),
    .alert_out(alert_out), .alert_oe(alert_oe), .fault_filter(fault_filter));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (reg_wr_stb) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= reg_wr_data;
    end
    if (oneshot_stb) os_cnt <= os_cnt + 1;
    if (status_rd_stb) st_cnt <= st_cnt + 1;
  end
  // ****************************************
  // transfers and scenarios
  // ****************************************
  // every transfer opens with its own start
  task automatic wr(input logic [6:0] a, input logic [7:0] pt, dt,
                    input int n);
    ak = 4'h0;
    m_u.start();
    m_u.wbyte({a, 1'b0}, ak[0]);
    m_u.wbyte(pt, ak[1]);
    for (int i = 2; i <= n; i++) m_u.wbyte(dt, ak[i]);
    m_u.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] o = 8'hFF);
    v = 8'h00;
    m_u.start();
    m_u.wbyte({a, 1'b1}, a1);
    if (a1) m_u.rbyte(o, v);
    m_u.stop();
  endtask
  task automatic tally_and_finish();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    m_u.w(8);
    `CHK("filter", 8'h01, fault_filter)
    for (int k = 0; k < 3; k++) begin
      p = k ? 8'h4C ^ (8'h02 + (8'($random(seed)) & 8'h1F)) : 8'h4D;
      wr(p[6:0], 8'h03, 8'h55, 2);
      `CHK("foreign ack", 4'h0, ak)
    end
    for (int k = 0; k < 4; k++) begin
      p = 8'($random(seed)) & 8'hD7;
      d = 8'($random(seed));
      wr(7'h4C, p, d, 2);
      `CHK("write acks", 4'h7, ak)
      `CHK("pointer", p, reg_ptr)
      `CHK("stored data", d, wr_last)
      wr(7'h4C, p ^ 8'h10, d, 1);
      rd(7'h4C);
      `CHK("read data", rdv(p ^ 8'h10), v)
      rd(7'h4C);
      `CHK("reread data", rdv(p ^ 8'h10), v)
    end
    wr(7'h4C, 8'h0F, d, 2);
    `CHK("oneshot count", 1, os_cnt)
    `CHK("store count", 4, wr_cnt)
    wr(7'h4C, p, d, 3);
    `CHK("third byte ack", 4'h7, ak)
    s0 = st_cnt;
    wr(7'h4C, 8'h02, d, 1);
    rd(7'h4C);
    `CHK("status reads", 1, st_cnt - s0)
    for (int en = 0; en < 2; en++) begin
      wr(7'h4C, 8'h22, {en[0], 7'h01}, 2);
      `CHK("filter", {en[0], 7'h01}, fault_filter)
      wr(7'h4C, 8'h22, d, 1);
      rd(7'h4C);
      `CHK("filter read", {en[0], 7'h01}, v)
      m_u.start();
      m_u.wbyte(8'h98, a1);
      m_u.w(300);
      m_u.wbyte(p, a1);
      m_u.stop();
      `CHK("ack after stall", !en[0], a1)
    end
    alert_mode = 1'b1;
    fault_active = 1'b1;
    status_latched = 1'b1;
    m_u.w(8);
    `CHK("alert raised", 1'b1, alert_oe)
    // a lower-addressed rival answers 0x87 and wins at bit 4
    rd(7'h0C, 8'h87);
    `CHK("lost arbitration", 8'h87, v)
    `CHK("alert kept", 1'b1, alert_oe)
    // response reads repeat while the alert stays low
    for (int k = 0; k < 3; k++) begin
      {fault_active, status_latched} = 2'b11 >> k;
      rd(7'h0C);
      `CHK("response ack", 1'b1, a1)
      `CHK("response addr", 8'h99, v)
      `CHK("alert held", k < 2, alert_oe)
    end
    rd(7'h0C);
    `CHK("quiet response", 1'b0, a1)
    alert_mode = 1'b0;
    fault_active = 1'b1;
    m_u.w(8);
    `CHK("alert unused", 1'b0, alert_oe)
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
